// *** ebt_cycle_timing.sv ***
// expansion bus cycle sequencer: latch strobe, command delay, wait states, DMA steering
`timescale 1ns/10ps
module ebt_cycle_timing
    import ebt_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // timing settings
    input wire logic [REG_W-1:0] i_latch_delay_reg,
    input wire logic [REG_W-1:0] i_latch_width_reg,
    input wire logic [REG_W-1:0] i_narrow_cmd_delay_reg,
    input wire logic [REG_W-1:0] i_narrow_wait_reg,
    input wire logic [REG_W-1:0] i_wide_io_wait_reg,
    input wire logic [REG_W-1:0] i_wide_mem_cmd_delay_reg,
    input wire logic [REG_W-1:0] i_wide_mem_wait_reg,
    input wire logic [REG_W-1:0] i_zero_wait_min_reg,
    // cycle request from local side
    input wire logic i_cycle_start,
    input wire logic i_cycle_mem,
    input wire logic i_mem_sel16,
    input wire logic i_io_sel16,
    // adapter handshake
    input wire logic i_chan_ready,
    input wire logic i_zero_wait_request,
    // dma control
    input wire logic i_dma_active,
    input wire logic i_addr_enable,
    input wire logic i_dma_io_to_mem16,
    input wire logic i_dma_mem_to_io,
    input wire logic i_primary_direction,
    // bus strobes and cycle status
    output logic o_bus_latch_strobe,
    output logic o_cmd_strobe,
    output logic o_cycle_done,
    output logic o_busy,
    output logic o_wide_cycle,
    // dma outputs
    output logic o_dma_cmd_enable,
    output logic o_secondary_buffer_enable,
    output logic o_secondary_direction,
    output logic o_dma_ready_out,
    output logic o_dma_mem_read_strobe,
    output logic o_delayed_write_strobe,
    output logic o_local_mem_read_strobe,
    output logic o_local_io_write_strobe
);
    ebt_state_e st_q;
    ebt_state_e st_d;
    logic [REG_W-1:0] ldly_q;
    logic [REG_W-1:0] lwid_q;
    logic [REG_W-1:0] cdly_q;
    logic [REG_W-1:0] wait_q;
    logic [REG_W-1:0] zmin_q;
    logic wide_q;
    logic latch_q;
    logic cmd_q;
    logic done_q;
    logic stall_q;
    logic mrd_q;
    logic dwr_q;
    logic iow_q;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] limit;
    logic cnt_last;
    logic wide_sel;
    logic wide_mem_sel;
    logic wide_io_sel;
    logic [REG_W-1:0] sel_cdly;
    logic [REG_W-1:0] sel_wait;
    logic [REG_W-1:0] cmd_waits;
    logic phase_end;
    logic cmd_end;
    logic dma_gate;
    logic start_ok;

    // first phase at or after 'from' whose length is not zero
    function automatic ebt_state_e ebt_skip(input ebt_state_e from, input logic [REG_W-1:0] a,
                                            input logic [REG_W-1:0] b, input logic [REG_W-1:0] c);
        ebt_state_e r;
        r = S_CMD;
        if (from == S_LDLY && a != REG_RESET) begin
            r = S_LDLY;
        end else if ((from == S_LDLY || from == S_LWID) && b != REG_RESET) begin
            r = S_LWID;
        end else if (c != REG_RESET) begin
            r = S_CDLY;
        end
        return r;
    endfunction : ebt_skip

    // select lines only looked at for the matching cycle type
    assign wide_mem_sel = i_cycle_mem & i_mem_sel16;
    assign wide_io_sel = ~i_cycle_mem & i_io_sel16;
    // dma cycles run with narrow timing whatever their width
    assign wide_sel = ~i_dma_active & (wide_mem_sel | wide_io_sel);
    assign sel_cdly = (wide_sel & i_cycle_mem) ? i_wide_mem_cmd_delay_reg : i_narrow_cmd_delay_reg;
    assign sel_wait = !wide_sel ? i_narrow_wait_reg :
                      i_cycle_mem ? i_wide_mem_wait_reg : i_wide_io_wait_reg;
    // zero-wait shortens to the minimum but never lengthens the cycle
    assign cmd_waits = (i_zero_wait_request && zmin_q < wait_q) ? zmin_q : wait_q;
    assign limit = (st_q == S_LDLY) ? {1'b0, ldly_q} :
                   (st_q == S_LWID) ? {1'b0, lwid_q} :
                   (st_q == S_CDLY) ? {1'b0, cdly_q} :
                   ({1'b0, cmd_waits} + CNT_ONE);
    assign phase_end = cnt_last;
    // ready low at the state end holds the command open
    assign cmd_end = cnt_last & i_chan_ready;
    assign start_ok = i_cycle_start & (st_q == S_IDLE);
    assign dma_gate = i_dma_active & i_addr_enable;

    always_comb begin
        st_d = st_q;
        case (st_q)
            S_IDLE: begin
                if (i_cycle_start) begin
                    st_d = ebt_skip(S_LDLY, i_latch_delay_reg, i_latch_width_reg, sel_cdly);
                end
            end
            S_LDLY: begin
                if (phase_end) begin
                    st_d = ebt_skip(S_LWID, ldly_q, lwid_q, cdly_q);
                end
            end
            S_LWID: begin
                if (phase_end) begin
                    st_d = ebt_skip(S_CDLY, ldly_q, lwid_q, cdly_q);
                end
            end
            S_CDLY: begin
                if (phase_end) begin
                    st_d = S_CMD;
                end
            end
            S_CMD: begin
                if (cmd_end) begin
                    st_d = S_IDLE;
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
    end

    ebt_phase_cnt u_cnt (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_clk_en(i_clk_en),
        .i_clear(st_d != st_q),
        .i_limit(limit),
        .o_count(cnt),
        .o_last(cnt_last)
    );

    // settings captured at cycle start so a rewrite cannot upset a running cycle
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ldly_q <= REG_RESET;
            lwid_q <= REG_RESET;
            cdly_q <= REG_RESET;
            wait_q <= REG_RESET;
            zmin_q <= REG_RESET;
            wide_q <= 1'b0;
        end else if (i_clk_en && start_ok) begin
            ldly_q <= i_latch_delay_reg;
            lwid_q <= i_latch_width_reg;
            cdly_q <= sel_cdly;
            wait_q <= sel_wait;
            zmin_q <= i_zero_wait_min_reg;
            wide_q <= wide_sel;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            st_q <= S_IDLE;
            latch_q <= 1'b0;
            cmd_q <= 1'b0;
            done_q <= 1'b0;
            stall_q <= 1'b0;
            mrd_q <= 1'b0;
            dwr_q <= 1'b0;
            iow_q <= 1'b0;
        end else if (i_clk_en) begin
            st_q <= st_d;
            latch_q <= (st_d == S_LWID);
            cmd_q <= (st_d == S_CMD);
            done_q <= (st_q == S_CMD) & cmd_end;
            stall_q <= (st_q == S_CMD) & cnt_last & ~i_chan_ready;
            mrd_q <= (st_d == S_CMD) & i_dma_active & i_dma_mem_to_io;
            dwr_q <= (st_d == S_CMD) & i_dma_active & ~i_dma_mem_to_io;
            iow_q <= (st_d == S_CMD) & i_dma_active & i_dma_mem_to_io;
        end
    end

    assign o_bus_latch_strobe = latch_q;
    assign o_cmd_strobe = cmd_q & (~i_dma_active | i_addr_enable);
    assign o_cycle_done = done_q;
    assign o_busy = (st_q != S_IDLE);
    assign o_wide_cycle = wide_q;
    assign o_dma_cmd_enable = dma_gate;
    assign o_secondary_buffer_enable = dma_gate & i_dma_io_to_mem16;
    assign o_secondary_direction = ~i_primary_direction;
    assign o_dma_mem_read_strobe = mrd_q & dma_gate;
    assign o_delayed_write_strobe = dwr_q & dma_gate;
    assign o_local_mem_read_strobe = mrd_q & dma_gate;
    assign o_local_io_write_strobe = iow_q & dma_gate;
    // ready only drops on an adapter stall or a memory-to-I/O read
    assign o_dma_ready_out = ~(i_dma_active & (stall_q | (i_dma_mem_to_io & mrd_q)));

    a_latch_width: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (st_q == S_LWID && !phase_end) |=> (st_q == S_LWID && o_bus_latch_strobe))
        else $error("latch strobe width cut short");
    a_latch_idle: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (st_q == S_LDLY) |-> ##1 (o_bus_latch_strobe == (st_q == S_LWID)))
        else $error("latch strobe high during delay");
    a_cmd_delay: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (st_q == S_CDLY && cnt < {1'b0, cdly_q} - CNT_ONE) |=> !cmd_q)
        else $error("command strobe early");
    a_wait_count: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (st_q == S_CMD && !i_zero_wait_request && cnt < {1'b0, wait_q}) |=> (st_q == S_CMD))
        else $error("command ended before wait states");
    a_wide_sel: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (start_ok && !i_cycle_mem && !i_io_sel16) |=> !o_wide_cycle)
        else $error("memory select used in I/O cycle");
    a_zero_min: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (st_q == S_CMD && cnt < {1'b0, zmin_q} && cnt < {1'b0, wait_q}) |=> (st_q == S_CMD))
        else $error("zero-wait cycle below minimum");
    a_ready_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (st_q == S_CMD && !i_chan_ready) |=> (st_q == S_CMD && (o_cmd_strobe || !i_addr_enable)))
        else $error("cycle ended while ready low");
    a_dma_gate: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (i_dma_active && !i_addr_enable) |-> !(o_cmd_strobe | o_dma_mem_read_strobe | o_delayed_write_strobe))
        else $error("dma command without address enable");
    a_sec_dir: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (dma_gate && i_dma_io_to_mem16) |-> (o_secondary_buffer_enable && o_secondary_direction != i_primary_direction))
        else $error("secondary buffer wrong in wide dma");
    a_dma_ready: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (i_dma_active && !i_dma_mem_to_io && !stall_q) |-> o_dma_ready_out)
        else $error("dma ready dropped without stall");
    a_settings_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (st_q != S_IDLE) |=> $stable(wait_q) && $stable(cdly_q))
        else $error("settings changed mid cycle");
endmodule : ebt_cycle_timing

// *** ebt_pkg.sv ***
// constants and types for the expansion bus cycle timing block
package ebt_pkg;
    localparam int REG_W = 4;
    localparam int CNT_W = 5;
    localparam int CLK_PERIOD_NS = 5;
    localparam logic [REG_W-1:0] REG_RESET = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    typedef enum logic [2:0] {
        S_IDLE,
        S_LDLY,
        S_LWID,
        S_CDLY,
        S_CMD
    } ebt_state_e;
endpackage : ebt_pkg

// *** ebt_phase_cnt.sv ***
// per-phase clock counter with end-of-phase compare
`timescale 1ns/10ps
module ebt_phase_cnt
    import ebt_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // control
    input wire logic i_clear,
    input wire logic [CNT_W-1:0] i_limit,
    // status
    output logic [CNT_W-1:0] o_count,
    output logic o_last
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] cnt_inc;

    // saturate so a long ready stall cannot wrap the compare
    assign cnt_inc = (cnt_q == {CNT_W{1'b1}}) ? cnt_q : cnt_q + CNT_ONE;
    assign cnt_d = i_clear ? CNT_ZERO : cnt_inc;
    assign o_count = cnt_q;
    assign o_last = ({1'b0, cnt_q} + {1'b0, CNT_ONE}) >= {1'b0, i_limit};

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            cnt_q <= CNT_ZERO;
        end else if (i_clk_en) begin
            cnt_q <= cnt_d;
        end
    end
endmodule : ebt_phase_cnt

// *** ebt_adapter_model.sv ***
// adapter card model: channel ready stall and zero-wait request
`timescale 1ns/10ps
module ebt_adapter_model
    import ebt_pkg::*;
(
    // clock
    input wire logic i_clk_sys,
    // control from bench
    input wire logic i_cmd_strobe,
    input wire logic [CNT_W-1:0] i_stall_limit,
    input wire logic i_zero_req,
    // bus lines
    output logic o_chan_ready,
    output logic o_zero_wait_request
);
    logic [CNT_W-1:0] hi_cnt_q;
    // ready is pulled up on the bus, so it reads high outside a stall
    assign o_chan_ready = !(i_cmd_strobe && (hi_cnt_q < i_stall_limit));
    assign o_zero_wait_request = i_zero_req;
    always_ff @(posedge i_clk_sys) begin
        hi_cnt_q <= i_cmd_strobe ? hi_cnt_q + CNT_ONE : CNT_ZERO;
    end
endmodule : ebt_adapter_model

// *** tb_ebt_cycle_timing.sv ***
// self-checking bench for the expansion bus cycle timing block
`timescale 1ns/10ps
module tb_ebt_cycle_timing
    import ebt_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, mem = 1'b0, ms16 = 1'b0, ios16 = 1'b0, zreq = 1'b0;
    logic dma = 1'b0, aen = 1'b0, io2m = 1'b0, m2io = 1'b0, pdir = 1'b0, rdy_ch, zw;
    logic [REG_W-1:0] r_ld = 4'h0, r_lw = 4'h1, r_nd = 4'h1, r_nw = 4'h1;
    logic [REG_W-1:0] r_wio = 4'h1, r_wmd = 4'h0, r_wmw = 4'h1, r_zm = 4'h0;
    logic [CNT_W-1:0] stall = 5'h00;
    logic lat, cmd, done, dce, sbe, sdir, rdy, dmr, dw, lmr, liw, busy, wide;
    logic en = 1'b1;
    int n_errors = 0, total_checks = 0, lf, lc, cf, cc, dn, mr, rb, sb, bc, chg = 0, frz = 0;
    int tab [3][8] = '{'{0, 1, 1, 4, 1, 0, 1, 0}, '{1, 2, 4, 8, 4, 2, 4, 2}, '{1, 2, 4, 10, 4, 2, 4, 2}};
    // write orders by table column; registers nine, ten and twelve live outside this block
    int ord_hi [8] = '{4, 5, 6, 7, 3, 2, 1, 0};
    int ord_lo [8] = '{4, 5, 6, 7, 0, 1, 2, 3};
    always #2.5 clk = ~clk;
    ebt_adapter_model i_adapter (.i_clk_sys(clk), .i_cmd_strobe(cmd), .i_stall_limit(stall),
        .i_zero_req(zreq), .o_chan_ready(rdy_ch), .o_zero_wait_request(zw));
    ebt_cycle_timing i_dut (.i_clk_sys(clk), .i_reset(rst), .i_clk_en(en),
        .i_latch_delay_reg(r_ld), .i_latch_width_reg(r_lw), .i_narrow_cmd_delay_reg(r_nd),
        .i_narrow_wait_reg(r_nw), .i_wide_io_wait_reg(r_wio), .i_wide_mem_cmd_delay_reg(r_wmd),
        .i_wide_mem_wait_reg(r_wmw), .i_zero_wait_min_reg(r_zm), .i_cycle_start(start),
        .i_cycle_mem(mem), .i_mem_sel16(ms16), .i_io_sel16(ios16), .i_chan_ready(rdy_ch),
        .i_zero_wait_request(zw), .i_dma_active(dma), .i_addr_enable(aen), .i_dma_io_to_mem16(io2m),
        .i_dma_mem_to_io(m2io), .i_primary_direction(pdir), .o_bus_latch_strobe(lat),
        .o_cmd_strobe(cmd), .o_cycle_done(done), .o_busy(busy), .o_wide_cycle(wide), .o_dma_cmd_enable(dce),
        .o_secondary_buffer_enable(sbe), .o_secondary_direction(sdir), .o_dma_ready_out(rdy),
        .o_dma_mem_read_strobe(dmr), .o_delayed_write_strobe(dw), .o_local_mem_read_strobe(lmr),
        .o_local_io_write_strobe(liw));

    task results;
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // four-state arguments so an unknown never slips through as zero
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %s seen %0d expected %0d", $time, what, seen, exp);
        end
    endtask : check

    // one register per clock, in the order that keeps strobes from getting too short
    task set_regs(input int t, input bit fast);
        int f;
        for (int i = 0; i < 8; i++) begin
            f = fast ? ord_hi[i] : ord_lo[i];
            @(posedge clk);
            case (f)
                0: r_ld <= REG_W'(tab[t][0]);
                1: r_lw <= REG_W'(tab[t][1]);
                2: r_nd <= REG_W'(tab[t][2]);
                3: r_nw <= REG_W'(tab[t][3]);
                4: r_wio <= REG_W'(tab[t][4]);
                5: r_wmd <= REG_W'(tab[t][5]);
                6: r_wmw <= REG_W'(tab[t][6]);
                default: r_zm <= REG_W'(tab[t][7]);
            endcase
        end
    endtask : set_regs

    // one bus cycle, counting strobe clocks from the start edge
    task run(input logic m, input logic m16, input logic i16, input logic z);
        lf = 0; lc = 0; cf = 0; cc = 0; dn = 0; mr = 0; rb = 0; sb = 0; bc = 0;
        @(posedge clk);
        start <= 1'b1; mem <= m; ms16 <= m16; ios16 <= i16; zreq <= z;
        for (int k = 1; k < 90 && dn == 0; k++) begin
            @(posedge clk);
            start <= 1'b0;
            if (k == 2 && chg != 0) r_nw <= 4'h1;
            if (frz != 0 && (k == 1 || k == 3)) en <= (k == 3);
            #1;
            if (busy === 1'b1) bc++;
            if (lat === 1'b1) begin lc++; if (lf == 0) lf = k; end
            if (cmd === 1'b1) begin cc++; if (cf == 0) cf = k; end
            if (dmr === 1'b1) begin mr++; if (rdy !== 1'b0) rb++; end
            if (dce !== (dma & aen) || sdir !== ~pdir || lmr !== dmr) sb++;
            if (dma === 1'b1 && (sbe !== (aen & io2m) || (m2io === 1'b0 && rdy !== 1'b1))) sb++;
            if (dma === 1'b1 && (dw !== (cmd & ~m2io) || liw !== (cmd & m2io) || dmr !== (cmd & m2io))) sb++;
            if (done === 1'b1) dn = k;
        end
    endtask : run

    // latch delay d, width w, command delay c, n wait states
    task expect_cycle(input int d, input int w, input int c, input int n);
        check(lf, d + 1, "latch strobe rise");
        check(lc, w, "latch strobe width");
        check(cf, d + w + c + 1, "command strobe rise");
        check(cc, n + 1, "command strobe length");
        check(dn, d + w + c + n + 2, "cycle done");
        check(bc, d + w + c + n + 1, "busy length");
    endtask : expect_cycle

    initial begin
        #200000;
        n_errors++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // recommended sets for the slow, middle and fast clocks
        for (int t = 0; t < 3; t++) begin
            set_regs(t, t != 0);
            run(1'b1, 1'b0, 1'b0, 1'b0);
            expect_cycle(tab[t][0], tab[t][1], tab[t][2], tab[t][3]);
            check(wide, 0, "narrow memory timing");
            run(1'b0, 1'b0, 1'b1, 1'b0);
            expect_cycle(tab[t][0], tab[t][1], tab[t][2], tab[t][4]);
            check(wide, 1, "wide I/O timing");
            run(1'b1, 1'b1, 1'b0, 1'b0);
            expect_cycle(tab[t][0], tab[t][1], tab[t][5], tab[t][6]);
            check(wide, 1, "wide memory timing");
            run(1'b1, 1'b1, 1'b0, 1'b1);
            expect_cycle(tab[t][0], tab[t][1], tab[t][5], (tab[t][7] < tab[t][6]) ? tab[t][7] : tab[t][6]);
            run(1'b1, 1'b0, 1'b1, 1'b0);
            expect_cycle(tab[t][0], tab[t][1], tab[t][2], tab[t][3]);
            check(wide, 0, "I/O select in memory cycle");
            run(1'b0, 1'b1, 1'b0, 1'b0);
            expect_cycle(tab[t][0], tab[t][1], tab[t][2], tab[t][3]);
            check(wide, 0, "memory select in I/O cycle");
        end
        // wait count rewritten mid cycle only counts from the next one
        chg = 1;
        run(1'b0, 1'b0, 1'b0, 1'b0);
        chg = 0;
        expect_cycle(1, 2, 4, 10);
        run(1'b0, 1'b0, 1'b0, 1'b0);
        expect_cycle(1, 2, 4, 1);
        // latch strobe widened by one clock
        @(posedge clk);
        r_lw <= 4'h3;
        run(1'b0, 1'b0, 1'b0, 1'b0);
        expect_cycle(1, 3, 4, 1);
        // two frozen clocks inside the latch delay stretch it by two
        frz = 1;
        run(1'b0, 1'b0, 1'b0, 1'b0);
        frz = 0;
        expect_cycle(3, 3, 4, 1);
        // ready held low for the first four command clocks: command stands five
        @(posedge clk);
        stall <= 5'h04;
        run(1'b0, 1'b0, 1'b0, 1'b0);
        expect_cycle(1, 3, 4, 4);
        // dma: 16-bit I/O to on-board memory, then memory to I/O, then no address enable
        @(posedge clk);
        stall <= 5'h00;
        dma <= 1'b1; aen <= 1'b1; io2m <= 1'b1; pdir <= 1'b1;
        run(1'b0, 1'b0, 1'b1, 1'b0);
        expect_cycle(1, 3, 4, 1);
        check(wide, 0, "dma forced to narrow timing");
        check(sb, 0, "dma steering or default ready");
        check(mr, 0, "memory read strobe in io to memory");
        @(posedge clk);
        io2m <= 1'b0; m2io <= 1'b1; pdir <= 1'b0;
        run(1'b0, 1'b0, 1'b0, 1'b0);
        expect_cycle(1, 3, 4, 1);
        check(mr, 2, "dma memory read length");
        check(rb, 0, "dma ready while memory read");
        check(sb, 0, "dma steering");
        @(posedge clk);
        aen <= 1'b0;
        run(1'b0, 1'b0, 1'b0, 1'b0);
        check(cc, 0, "command without address enable");
        check(sb, 0, "dma command enable");
        results();
    end
endmodule : tb_ebt_cycle_timing
